// ===== design/tmwm_pkg.sv
// Package for the 8-bit timer waveform and compare-output block.
// Assumes a single system clock; shared by the top and the register module.
package tmwm_pkg;
  localparam logic [2:0] ADDR_CTRL_A  = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B  = 3'h1;
  localparam logic [2:0] ADDR_COUNT   = 3'h2;
  localparam logic [2:0] ADDR_CMP_A   = 3'h3;
  localparam logic [2:0] ADDR_CMP_B   = 3'h4;
  localparam logic [2:0] ADDR_STATUS  = 3'h5;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_B_WMASK = 8'h08;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_ONE    = 8'h01;
  localparam int         COM_A_HI     = 7;
  localparam int         COM_A_LO     = 6;
  localparam int         COM_B_HI     = 5;
  localparam int         COM_B_LO     = 4;
  localparam int         MODE_HI_POS  = 3;
  localparam int         TOV_POS      = 0;

  typedef enum logic [2:0] {
    TMWM_NORMAL    = 3'h0,
    TMWM_PC_FF     = 3'h1,
    TMWM_CTC       = 3'h2,
    TMWM_FAST_FF   = 3'h3,
    TMWM_RSVD4     = 3'h4,
    TMWM_PC_CMP    = 3'h5,
    TMWM_RSVD6     = 3'h6,
    TMWM_FAST_CMP  = 3'h7
  } tmwm_mode_t;

  typedef enum logic [1:0] {
    TMWM_COM_OFF = 2'h0,
    TMWM_COM_TGL = 2'h1,
    TMWM_COM_CLR = 2'h2,
    TMWM_COM_SET = 2'h3
  } tmwm_com_t;
endpackage

// ===== design/tmwm_regs.sv
// Register slave for the timer: control A/B and both compare buffers.
// Assumes one-cycle read/write strobes from a master on the same clock.
module tmwm_regs
  import tmwm_pkg::*;
(
  input  wire logic       sys_clk_in,    // System clock
  input  wire logic       rstn_in,       // Async reset, active low
  input  wire logic       ce_in,         // Clock enable
  input  wire logic [2:0] addr_in,       // Register index
  input  wire logic [7:0] wdata_in,      // Write data
  input  wire logic       wr_in,         // Write strobe
  output logic      [7:0] ctrl_a_out,    // Control A
  output logic            mode_hi_out,   // Top mode bit
  output logic      [7:0] cmp_a_buf_out, // Buffered compare A
  output logic      [7:0] cmp_b_buf_out  // Buffered compare B
);
  wire wr_a  = ce_in && wr_in && (addr_in == ADDR_CTRL_A);
  wire wr_b  = ce_in && wr_in && (addr_in == ADDR_CTRL_B);
  wire wr_ca = ce_in && wr_in && (addr_in == ADDR_CMP_A);
  wire wr_cb = ce_in && wr_in && (addr_in == ADDR_CMP_B);

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_a_out    <= CTRL_A_RESET;
      mode_hi_out   <= 1'b0;
      cmp_a_buf_out <= BYTE_ZERO;
      cmp_b_buf_out <= BYTE_ZERO;
    end
    else
    begin
      if (wr_a)
        ctrl_a_out <= wdata_in & CTRL_A_WMASK; // R12
      if (wr_b)
        mode_hi_out <= wdata_in[MODE_HI_POS]; // R19
      if (wr_ca)
        cmp_a_buf_out <= wdata_in;
      if (wr_cb)
        cmp_b_buf_out <= wdata_in;
    end
  end

  chk_ctrl_reserved_zero : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    ctrl_a_out[3:2] == 2'h0) else $error("control A reserved bits not zero"); // R12
  chk_ctrl_reset_zero : assert property (@(posedge sys_clk_in)
    $rose(rstn_in) |-> ctrl_a_out == CTRL_A_RESET) // R21
    else $error("control A not zero after reset");
endmodule

// ===== design/tmwm_top.sv
// Waveform generation and compare-output control for an 8-bit timer.
// Assumes a register master on sys_clk_in; pin direction is handled outside.
// Overview of operation
// R1: Nonzero output mode drives pin from waveform
// R2: Software sets port direction to output
// R3: Channel A non-PWM: off, toggle, clear, set
// R4: Channel B non-PWM: same decoding on match
// R5: Fast PWM A 01: toggle only if top-bit
// R6: Fast PWM A: 10 clear/set-top, 11 inverse
// R7: Fast PWM B: 10/11 like A, 01 reserved
// R8: Phase PWM A: 10 clear up, set down
// R9: Phase PWM A 01: toggle only if top-bit
// R10: Phase PWM B: 11 set up; 01 reserved
// R11: Compare equal top ignored; top action stays
// R12: Control A bits 3,2 read zero
// R13: Mode field selects mode and top source
// R14: Mode 3: top FF, buffered, flag at max
// R15: Modes 4 and 6 do not count
// R16: Buffer load and overflow point per mode
// R17: Fast PWM wraps to zero after top
// R18: Phase PWM counts up then down
// R19: Top mode bit is control B bit 3
// R20: CLEAR_ON_COMPARE_MODE clears after match; normal wraps
// R21: Control A resets to zero
module tmwm_top
  import tmwm_pkg::*;
(
  input  wire logic       sys_clk_in, // 40 MHz clock
  input  wire logic       rstn_in,    // Async reset, active low
  input  wire logic       ce_in,      // Clock enable, freezes state
  input  wire logic       tick_in,    // Timer count enable (prescaled)
  input  wire logic [2:0] addr_in,    // Register index
  input  wire logic [7:0] wdata_in,   // Write data
  input  wire logic       wr_in,      // Write strobe
  input  wire logic       rd_in,      // Read strobe
  output logic      [7:0] rdata_out,  // Read data, cycle after strobe
  output logic            wave_a_out, // chan_a_wave_pin level
  output logic            wave_a_en_out, // Channel A owns the pin
  output logic            wave_b_out, // chan_b_wave_pin level
  output logic            wave_b_en_out, // Channel B owns the pin
  output logic            ovf_out     // overflow_flag level
);
  logic [7:0] ctrl_a;
  logic       mode_hi;
  logic [7:0] cmp_a_buf;
  logic [7:0] cmp_b_buf;
  logic [7:0] count_value;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic       down;
  logic       block_match;
  logic       overflow_flag;

  tmwm_regs u_regs (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .ce_in         (ce_in),
    .addr_in       (addr_in),
    .wdata_in      (wdata_in),
    .wr_in         (wr_in),
    .ctrl_a_out    (ctrl_a),
    .mode_hi_out   (mode_hi),
    .cmp_a_buf_out (cmp_a_buf),
    .cmp_b_buf_out (cmp_b_buf)
  );

  wire tmwm_com_t  com_a = tmwm_com_t'(ctrl_a[COM_A_HI:COM_A_LO]);
  wire tmwm_com_t  com_b = tmwm_com_t'(ctrl_a[COM_B_HI:COM_B_LO]);
  wire tmwm_mode_t mode  = tmwm_mode_t'({mode_hi, ctrl_a[1:0]}); // R19

  wire is_fast  = (mode == TMWM_FAST_FF) || (mode == TMWM_FAST_CMP);
  wire is_pc    = (mode == TMWM_PC_FF) || (mode == TMWM_PC_CMP);
  wire is_pwm   = is_fast || is_pc;
  wire is_rsvd  = (mode == TMWM_RSVD4) || (mode == TMWM_RSVD6); // R15
  wire top_cmpa = (mode == TMWM_CTC) || (mode == TMWM_PC_CMP) || (mode == TMWM_FAST_CMP);
  wire [7:0] top_val = top_cmpa ? cmp_a : COUNT_MAX; // R13

  wire step     = ce_in && tick_in && !is_rsvd; // R15
  wire at_top   = (count_value == top_val);
  wire at_bot   = (count_value == COUNT_BOTTOM);
  wire pc_turn_dn = is_pc && !down && at_top;
  wire pc_turn_up = is_pc && down && at_bot;
  wire next_down  = pc_turn_dn ? 1'b1 : (pc_turn_up ? 1'b0 : down); // R18
  wire wrap_zero  = at_top && (is_fast || mode == TMWM_CTC); // R17 R20
  wire cnt_wr     = ce_in && wr_in && (addr_in == ADDR_COUNT);

  // Phase PWM counts up to top then down to bottom; direction flips at the ends
  wire [7:0] next_count =
    wrap_zero ? COUNT_BOTTOM :
    (is_pc && next_down) ? count_value - COUNT_ONE :
    count_value + COUNT_ONE; // R18 R20

  // Buffers load at top in PWM modes, straight through otherwise
  wire load_cmp = !is_pwm || (step && at_top); // R16 R14

  wire match_a = step && !block_match && (count_value == cmp_a);
  wire match_b = step && !block_match && (count_value == cmp_b);
  // Cleared from top to bottom in fast PWM: the end-of-period action
  wire fast_top = step && is_fast && at_top;

  // Overflow at max unless phase correct, where it is bottom
  wire ovf_set = step && (is_pc ? (down && at_bot) : (count_value == COUNT_MAX)); // R16 R14
  wire ovf_clr = ce_in && wr_in && (addr_in == ADDR_STATUS) && wdata_in[TOV_POS];

  function automatic logic next_pin(input logic cur, input tmwm_com_t com, input logic is_b,
                                    input logic match, input logic eq_top);
    logic r;
    r = cur;
    if (!is_pwm)
    begin
      if (match) // R3 R4
      begin
        case (com)
          TMWM_COM_TGL: r = !cur;
          TMWM_COM_CLR: r = 1'b0;
          TMWM_COM_SET: r = 1'b1;
          default:      r = cur;
        endcase
      end
    end
    else if (com == TMWM_COM_TGL)
    begin
      if (match && !is_b && mode_hi) // R5 R9 R7 R10
        r = !cur;
    end
    else if (com[1])
    begin
      if (is_fast)
      begin
        if (fast_top)
          r = !com[0]; // R6 R7
        else if (match && !eq_top) // R11
          r = com[0];
      end
      else if (eq_top)
      begin
        // A compare at top holds the down-slope level, so a full compare stays put
        if (step && pc_turn_dn)
          r = !com[0]; // R11
      end
      else if (match)
        // The turn at bottom counts as up-slope: a zero compare never pulses
        r = (down && !at_bot) ? !com[0] : com[0]; // R8 R10
    end
    return r;
  endfunction

  logic next_wave_a;
  logic next_wave_b;

  // A process rather than a net assignment: the decode reads mode and counter
  // terms outside its arguments and must wake on them as well
  always_comb
  begin
    next_wave_a = next_pin(wave_a_out, com_a, 1'b0, match_a, cmp_a == top_val);
    next_wave_b = next_pin(wave_b_out, com_b, 1'b1, match_b, cmp_b == top_val);
  end
  wire pin_a_en    = (com_a != TMWM_COM_OFF) &&
                     !(is_pwm && com_a == TMWM_COM_TGL && !mode_hi); // R1 R5 R9
  wire pin_b_en    = (com_b != TMWM_COM_OFF) &&
                     !(is_pwm && com_b == TMWM_COM_TGL); // R1 R7 R10

  wire [7:0] rd_mux =
    (addr_in == ADDR_CTRL_A) ? ctrl_a :
    (addr_in == ADDR_CTRL_B) ? {4'h0, mode_hi, 3'h0} :
    (addr_in == ADDR_COUNT)  ? count_value :
    (addr_in == ADDR_CMP_A)  ? cmp_a_buf :
    (addr_in == ADDR_CMP_B)  ? cmp_b_buf :
    (addr_in == ADDR_STATUS) ? {7'h00, overflow_flag} : BYTE_ZERO;

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count_value <= COUNT_BOTTOM;
      down        <= 1'b0;
      block_match <= 1'b0;
      cmp_a       <= BYTE_ZERO;
      cmp_b       <= BYTE_ZERO;
    end
    else if (ce_in)
    begin
      // A count write suppresses the compare on the next timer step
      if (cnt_wr)
        block_match <= 1'b1;
      else if (step)
        block_match <= 1'b0;
      if (cnt_wr)
        count_value <= wdata_in;
      else if (step)
      begin
        count_value <= next_count;
        down        <= next_down;
      end
      if (!is_pc)
        down <= 1'b0;
      if (load_cmp)
      begin
        cmp_a <= cmp_a_buf;
        cmp_b <= cmp_b_buf;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wave_a_out    <= 1'b0;
      wave_b_out    <= 1'b0;
      wave_a_en_out <= 1'b0;
      wave_b_en_out <= 1'b0;
      overflow_flag <= 1'b0;
      rdata_out     <= BYTE_ZERO;
    end
    else if (ce_in)
    begin
      wave_a_out    <= next_wave_a;
      wave_b_out    <= next_wave_b;
      wave_a_en_out <= pin_a_en;
      wave_b_en_out <= pin_b_en;
      // Set wins over a clear in the same cycle
      overflow_flag <= ovf_set || (overflow_flag && !ovf_clr);
      rdata_out     <= rd_in ? rd_mux : BYTE_ZERO;
    end
  end

  assign ovf_out = overflow_flag;

  sequence s_fast_top_step;
    ce_in && step && is_fast && at_top && !cnt_wr;
  endsequence

  chk_fast_wrap_zero : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_fast_top_step |=> count_value == COUNT_BOTTOM) else $error("fast PWM no wrap"); // R17
  chk_ctc_wrap_zero : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (step && mode == TMWM_CTC && at_top && !cnt_wr) |=> count_value == COUNT_BOTTOM) // R20
    else $error("CLEAR_ON_COMPARE_MODE no clear");
  chk_pc_turn_down : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (step && pc_turn_dn && !cnt_wr && count_value != COUNT_BOTTOM) |=> down) // R18
    else $error("phase PWM no turn");
  chk_rsvd_hold : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && is_rsvd && !cnt_wr) |=> $stable(count_value)) // R15
    else $error("reserved mode counted");
  chk_ovf_max_set : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (step && !is_pc && count_value == COUNT_MAX) |=> overflow_flag) // R14 R16
    else $error("overflow not set at max");
  chk_pwm_buf_hold : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && is_pwm && !(step && at_top)) |=> $stable(cmp_a)) // R16
    else $error("PWM compare loaded off top");
  chk_fast_set_top : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (s_fast_top_step and (com_a == TMWM_COM_CLR)) |=> wave_a_out) // R6 R11
    else $error("fast PWM top not set");
  chk_pin_a_own : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && !is_pwm && com_a != TMWM_COM_OFF) |=> wave_a_en_out) // R1
    else $error("channel A pin not owned");
  chk_nonpwm_toggle : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (!is_pwm && match_a && com_a == TMWM_COM_TGL) |=> wave_a_out != $past(wave_a_out)) // R3
    else $error("toggle missing");
  chk_b_clear_match : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (!is_pwm && match_b && com_b == TMWM_COM_CLR) |=> !wave_b_out) // R4
    else $error("B clear missing");
  chk_pc_up_clear : assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (is_pc && match_a && !down && com_a == TMWM_COM_CLR && cmp_a != top_val)
    |=> !wave_a_out) else $error("phase up clear missing"); // R8

  sequence s_pc_turn_up_step;
    step && pc_turn_up && !cnt_wr;
  endsequence

  chk_pin_b_own : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R1
    (ce_in && !is_pwm && com_b != TMWM_COM_OFF) |=> wave_b_en_out)
    else $error("channel B pin not owned");
  chk_pin_a_off : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R1
    (ce_in && com_a == TMWM_COM_OFF) |=> !wave_a_en_out)
    else $error("channel A pin owned while off");
  chk_pwm_tgl_off : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R5 R9
    (ce_in && is_pwm && com_a == TMWM_COM_TGL && !mode_hi) |=> !wave_a_en_out)
    else $error("channel A toggle owns pin");
  chk_b_rsvd_off : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R7 R10
    (ce_in && is_pwm && com_b == TMWM_COM_TGL) |=> !wave_b_en_out)
    else $error("channel B reserved owns pin");
  chk_a_set_match : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R3
    (!is_pwm && match_a && com_a == TMWM_COM_SET) |=> wave_a_out)
    else $error("A set missing");
  chk_b_set_match : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R4
    (!is_pwm && match_b && com_b == TMWM_COM_SET) |=> wave_b_out)
    else $error("B set missing");
  chk_fast_clr_top : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R6 R11
    (s_fast_top_step and (com_a == TMWM_COM_SET)) |=> !wave_a_out)
    else $error("fast PWM top not cleared");
  chk_fast_b_top : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R7
    (s_fast_top_step and (com_b == TMWM_COM_CLR)) |=> wave_b_out)
    else $error("fast PWM B top not set");
  chk_pc_down_set : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R8
    (is_pc && match_a && down && !at_bot && com_a == TMWM_COM_CLR && cmp_a != top_val)
    |=> wave_a_out) else $error("phase down set missing");
  chk_pc_b_set : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R10
    (is_pc && match_b && !down && com_b == TMWM_COM_SET && cmp_b != top_val)
    |=> wave_b_out) else $error("phase B up set missing");
  chk_pc_ovf_bottom : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R16
    s_pc_turn_up_step |=> overflow_flag)
    else $error("overflow not set at bottom");
  chk_pwm_a_toggle : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R5 R9
    (is_pwm && match_a && com_a == TMWM_COM_TGL && mode_hi) |=> wave_a_out != $past(wave_a_out))
    else $error("PWM toggle missing");
  chk_pc_turn_up : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R18
    s_pc_turn_up_step |=> !down)
    else $error("phase PWM no turn up");
  chk_normal_wrap : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R20
    (step && mode == TMWM_NORMAL && count_value == COUNT_MAX && !cnt_wr) |=> count_value == COUNT_BOTTOM)
    else $error("normal mode no wrap");
  chk_nonpwm_load : assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R16
    (ce_in && !is_pwm) |=> cmp_a == $past(cmp_a_buf))
    else $error("compare not loaded at once");
endmodule

// ===== bench/tb_tmwm_top.sv
// Testbench for the timer waveform block: registers, counting, duty per mode.
// Assumes tmwm_pkg and tmwm_top are compiled first; the timer ticks every cycle from the reserved-mode tests on.
module tb_tmwm_top
  import tmwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk_in = 1'b0;
  logic       rstn_in    = 1'b0;
  logic       ce_in      = 1'b1;
  logic       tick_in    = 1'b0;
  logic [2:0] addr_in    = 3'h0;
  logic [7:0] wdata_in   = 8'h00;
  logic       wr_in      = 1'b0;
  logic       rd_in      = 1'b0;
  logic [7:0] rdata_out;
  logic       wave_a_out;
  logic       wave_a_en_out;
  logic       wave_b_out;
  logic       wave_b_en_out;
  logic       ovf_out;
  int         fails      = 0;
  int         n_checks   = 0;
  int         cyc        = 0;

  // Rows of {mode, channel A setting, channel B setting}
  localparam logic [6:0] TBL [16] = '{7'h1f, 7'h07, 7'h3b, 7'h2a, 7'h7a, 7'h57, 7'h3e, 7'h2d,
                                      7'h1a, 7'h09, 7'h3b, 7'h26, 7'h77, 7'h5b, 7'h3e, 7'h7f};

  tmwm_top dut (.sys_clk_in, .rstn_in, .ce_in, .tick_in, .addr_in, .wdata_in, .wr_in,
                .rd_in, .rdata_out, .wave_a_out, .wave_a_en_out, .wave_b_out,
                .wave_b_en_out, .ovf_out);

  always #12.5 sys_clk_in = ~sys_clk_in;

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Worst case is 16 rows of about 2700 cycles each
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, rdata_out});
  endtask

  // High cycles over two counter periods; a toggle setting gives one period
  function automatic logic [15:0] exp_hi(logic [2:0] m, logic [1:0] c, int cv, int ca);
    int t;
    int p;
    int r;
    t = (m == 3'h7 || m == 3'h5 || m == 3'h2) ? ca : 255;
    p = (m == 3'h1 || m == 3'h5) ? 2 * t : t + 1;
    if (c == 2'h1)
      r = p;
    else if (m == 3'h0 || m == 3'h2)
      r = (c == 2'h3) ? 2 * p : 0;
    else if (m == 3'h1 || m == 3'h5)
      r = (c == 2'h2) ? 4 * cv : 2 * (p - 2 * cv);
    else
      r = (c == 2'h2) ? 2 * (cv + 1) : 2 * (t - cv);
    return 16'(r);
  endfunction

  initial
  begin
    logic [7:0] ca;
    logic [7:0] cb;
    logic [2:0] m;
    logic [1:0] ac;
    logic [1:0] bc;
    int         ha;
    int         hb;
    int         p;
    void'($urandom(32'h6dd1));
    repeat (6) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rchk("ctrl_a_reset", ADDR_CTRL_A, 8'h00);
    chk("en_a_reset", 16'h0, {15'h0, wave_a_en_out});
    chk("en_b_reset", 16'h0, {15'h0, wave_b_en_out});
    wr(ADDR_CTRL_A, 8'hff);
    rchk("ctrl_a_rsvd", ADDR_CTRL_A, 8'hf3);
    wr(ADDR_CTRL_B, 8'hff);
    rchk("ctrl_b_mode_hi", ADDR_CTRL_B, 8'h08);
    rchk("unmapped", 3'h6, 8'h00);
    ca = 8'($urandom);
    wr(ADDR_CMP_B, ca);
    rchk("cmp_b_rw", ADDR_CMP_B, ca);
    @(posedge sys_clk_in);
    ce_in <= 1'b0;
    wr(ADDR_CTRL_A, 8'h00);
    @(posedge sys_clk_in);
    ce_in <= 1'b1;
    rchk("ce_freeze", ADDR_CTRL_A, 8'hf3);
    $display("test registers done");
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CTRL_A, 8'h43);
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk("fast_a01_off", 16'h0, {15'h0, wave_a_en_out});
    wr(ADDR_CTRL_A, 8'h51);
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk("phase_a01_off", 16'h0, {15'h0, wave_a_en_out});
    chk("phase_b01_off", 16'h0, {15'h0, wave_b_en_out});
    wr(ADDR_COUNT, 8'h33);
    wr(ADDR_CTRL_B, 8'h08);
    wr(ADDR_CTRL_A, 8'h00);
    tick_in <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
    rchk("mode4_frozen", ADDR_COUNT, 8'h33);
    wr(ADDR_CTRL_A, 8'h02);
    repeat (20) @(posedge sys_clk_in);
    rchk("mode6_frozen", ADDR_COUNT, 8'h33);
    $display("test reserved modes done");
    for (int k = 0; k < 16; k++)
    begin
      {m, ac, bc} = TBL[k];
      // First pass pins compares at their extremes, second pass draws them
      ca = (k < 8) ? 8'hff : 8'(8'h10 + ($urandom % 239));
      cb = (k < 8) ? ((m == 3'h5 || m == 3'h7) ? ca : 8'h00) : 8'($urandom % (ca + 1));
      wr(ADDR_CMP_A, ca);
      wr(ADDR_CMP_B, cb);
      wr(ADDR_CTRL_B, {4'h0, m[2], 3'h0});
      wr(ADDR_CTRL_A, {ac, bc, 2'h0, m[1:0]});
      wr(ADDR_COUNT, 8'h00);
      // Two longest periods let buffered compares and the new top settle
      repeat (1100) @(posedge sys_clk_in);
      p = int'(exp_hi(m, 2'h1, 0, ca));
      ha = 0;
      hb = 0;
      repeat (2 * p)
      begin
        @(posedge sys_clk_in);
        #1;
        ha += (wave_a_out === 1'b1) ? 1 : 0;
        hb += (wave_b_out === 1'b1) ? 1 : 0;
      end
      chk("duty_a", exp_hi(m, ac, ca, ca), 16'(ha));
      chk("duty_b", exp_hi(m, bc, cb, ca), 16'(hb));
      chk("en_a", 16'h1, {15'h0, wave_a_en_out});
      chk("en_b", 16'h1, {15'h0, wave_b_en_out});
      wr(ADDR_STATUS, 8'h01);
      repeat (p + 4) @(posedge sys_clk_in);
      #1;
      if (ca == 8'hff || !(m == 3'h2 || m == 3'h7))
        chk("ovf", 16'h1, {15'h0, ovf_out});
      else
        rchk("ovf_clear", ADDR_STATUS, 8'h00);
      $display("test mode %0d row %0d done", m, k);
    end
    conclude();
  end
endmodule
